/* rtl/mvps_cfg.svh */
// Offsets, field positions, reset values for the MSI pending block
`ifndef MVPS_CFG_SVH
`define MVPS_CFG_SVH

`define MVPS_ADDR_W 12
`define MVPS_OFF_CTRL 12'h048
`define MVPS_OFF_MASK64 12'h058
`define MVPS_OFF_MASK32 12'h054
`define MVPS_OFF_PEND64 12'h05C
`define MVPS_OFF_PEND32 12'h058
`define MVPS_OFF_CAPHDR 12'h068
`define MVPS_OFF_RSV0 12'h07C
`define MVPS_OFF_RSV1 12'h080
`define MVPS_OFF_RSV2 12'h08C
`define MVPS_OFF_RSV3 12'h090

`define MVPS_EN_BIT 16
`define MVPS_CAP_LSB 17
`define MVPS_CAP_MSB 19
`define MVPS_GRANT_LSB 20
`define MVPS_GRANT_MSB 22
`define MVPS_A64_BIT 23
`define MVPS_PVM_BIT 24

`define MVPS_CAP_ID 8'h10
`define MVPS_NEXT_PTR 8'hA4
`define MVPS_CAP_VER 4'h2
`define MVPS_PORT_TYPE 4'h0
`define MVPS_MSG_NUM 5'h00

`define MVPS_GRANT_1 3'h0
`define MVPS_GRANT_2 3'h1
`define MVPS_GRANT_4 3'h2
`define MVPS_CAP_COUNT 3'h2

`define MVPS_CAT_LINK 2'h1
`define MVPS_MASK_RST 4'h0
`define MVPS_PEND_RST 4'h0
`define MVPS_IMPL_1 4'h1
`define MVPS_IMPL_2 4'h3
`define MVPS_IMPL_4 4'hF

`endif

/* rtl/mvps_pkg.sv */
// Types and vector grouping functions for the MSI pending block
package mvps_pkg;
`include "mvps_cfg.svh"

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } mvps_state_t;

   // Bit 0 power/link state, 1 link port, 2 pin, 3 doorbell
   typedef struct packed {
      logic doorbell;
      logic gpio;
      logic link;
      logic power;
   } mvps_evt_t;

   typedef struct packed {
      logic enable;
      logic [2:0] grant;
   } mvps_ctrl_t;

   // Granted count limited by capability, saturated at four
   function automatic logic [2:0] mvps_eff_grant(input logic [2:0] en,
                                                input logic [2:0] cap);
      logic [2:0] g;
      g = (en < cap) ? en : cap;
      if (g > `MVPS_GRANT_4) begin
         g = `MVPS_GRANT_4;
      end
      return g;
   endfunction : mvps_eff_grant

   // Vector used by a category under a grant
   function automatic logic [1:0] mvps_vec_of(input logic [2:0] g,
                                             input logic [1:0] cat);
      logic [1:0] v;
      v = 2'h0;
      if (g >= `MVPS_GRANT_4) begin
         v = cat;
      end else if (g == `MVPS_GRANT_2) begin
         v = (cat == `MVPS_CAT_LINK) ? 2'h1 : 2'h0;
      end
      return v;
   endfunction : mvps_vec_of

endpackage : mvps_pkg

/* rtl/mvps_vector_map.sv */
// Folding of category pending bits onto granted vectors
`timescale 1ns/10ps
`include "mvps_cfg.svh"
module mvps_vector_map import mvps_pkg::*; (
   input wire logic [2:0] grant, // Effective grant field
   input wire mvps_evt_t catPend, // Pending per category
   input wire logic [3:0] maskBits, // Mask per vector
   output logic [3:0] vecPend, // Pending per vector
   output logic [3:0] vecLive, // Pending and unmasked
   output logic [3:0] implBits // Implemented bit positions
);

   always_comb begin
      vecPend = 4'h0;
      for (int c = 0; c < 4; c++) begin
         if (catPend[c]) begin
            vecPend[mvps_vec_of(grant, 2'(c))] = 1'b1;
         end
      end
   end

   always_comb begin
      if (grant >= `MVPS_GRANT_4) begin
         implBits = `MVPS_IMPL_4;
      end else if (grant == `MVPS_GRANT_2) begin
         implBits = `MVPS_IMPL_2;
      end else begin
         implBits = `MVPS_IMPL_1;
      end
   end

   assign vecLive = vecPend & ~maskBits & implBits;

endmodule : mvps_vector_map

/* rtl/mvps_msi_pending.sv */
// MSI pending status, vector grouping and express capability header
// Operation
// - Four interrupt source categories kept apart
// - Vector count from capable and granted fields
// - Four granted: one vector per category
// - Two granted: link port alone, rest shared
// - One granted: everything on one vector
// - Pending register at 5Ch, else 58h
// - Masked pending vector sends no message
// - Power pending bit only with four vectors
// - Bit zero shows shared pending otherwise
// - Link pending bit needs two vectors
// - Pin and doorbell bits need four vectors
// - Capability identifier reads 10h
// - Next capability pointer reads A4h
// - Capability version reads 2h
// - Port type reads zero, endpoint
// - Slot implemented bit reads zero
// - Interrupt message number defaults zero
// - Offsets 7Ch 80h 8Ch 90h reserved
// - Mask bits read-write, reset zero
// - Per-vector masking bit reads one
`timescale 1ns/10ps
`include "mvps_cfg.svh"
module mvps_msi_pending import mvps_pkg::*; #(
   parameter logic [2:0] CAP_COUNT = `MVPS_CAP_COUNT,
   parameter logic ADDR64 = 1'b1,
   parameter logic [4:0] MSG_NUM = `MVPS_MSG_NUM
) (
   input wire logic mclk, // Core clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic [`MVPS_ADDR_W-1:0] regAddr, // Register byte address
   input wire logic [31:0] regWrData, // Write data
   input wire logic regWrEn, // Write strobe
   input wire logic regRdEn, // Read strobe
   output logic [31:0] regRdData, // Read data, cycle after strobe
   input wire mvps_evt_t evtIn, // Category event pulses
   output logic msiValid, // Message request
   output logic [1:0] msiVector, // Vector of the request
   input wire logic msiReady // Message accepted
);

   ////////////////////////////////////////////////////////////////////
   // Registers and decode

   mvps_ctrl_t ctrlReg;
   logic [3:0] maskReg;
   mvps_evt_t catPendReg;
   mvps_evt_t catPendNext;
   mvps_state_t stateReg;
   logic [1:0] msiVecReg;
   logic [1:0] pickVec;
   logic [31:0] rdDataReg;
   logic [31:0] rdDataNext;
   logic [2:0] effGrant;
   logic [3:0] vecPend;
   logic [3:0] vecLive;
   logic [3:0] implBits;
   logic [3:0] catClear;
   logic [`MVPS_ADDR_W-1:0] pendAddr;
   logic [`MVPS_ADDR_W-1:0] maskAddr;
   logic sendDone;

   assign effGrant = mvps_eff_grant(ctrlReg.grant, CAP_COUNT);
   assign pendAddr = ADDR64 ? `MVPS_OFF_PEND64 : `MVPS_OFF_PEND32;
   assign maskAddr = ADDR64 ? `MVPS_OFF_MASK64 : `MVPS_OFF_MASK32;
   assign sendDone = (stateReg == ST_SEND) && msiReady;

   mvps_vector_map uMap (
      .grant(effGrant),
      .catPend(catPendReg),
      .maskBits(maskReg),
      .vecPend(vecPend),
      .vecLive(vecLive),
      .implBits(implBits)
   );

   ////////////////////////////////////////////////////////////////////
   // Software writes

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrlReg <= '0;
      end else if (regWrEn && regAddr == `MVPS_OFF_CTRL) begin
         ctrlReg.enable <= regWrData[`MVPS_EN_BIT];
         ctrlReg.grant <= regWrData[`MVPS_GRANT_MSB:`MVPS_GRANT_LSB];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         maskReg <= `MVPS_MASK_RST;
      end else if (regWrEn && regAddr == maskAddr) begin
         maskReg <= regWrData[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Category pending bits

   always_comb begin
      catClear = 4'h0;
      for (int c = 0; c < 4; c++) begin
         if (sendDone && mvps_vec_of(effGrant, 2'(c)) == msiVecReg) begin
            catClear[c] = 1'b1;
         end
      end
   end

   // New event wins over the clear of a sent message
   always_comb begin
      catPendNext = (catPendReg & ~catClear) | evtIn;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         catPendReg <= `MVPS_PEND_RST;
      end else begin
         catPendReg <= catPendNext;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Message request engine

   always_comb begin
      pickVec = 2'h0;
      for (int v = 3; v >= 0; v--) begin
         if (vecLive[v]) begin
            pickVec = 2'(v);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stateReg <= ST_IDLE;
      end else begin
         case (stateReg)
            ST_IDLE: begin
               if (ctrlReg.enable && |vecLive) begin
                  stateReg <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (msiReady) begin
                  stateReg <= ST_IDLE;
               end
            end
            default: begin
               stateReg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         msiVecReg <= 2'h0;
      end else if (stateReg == ST_IDLE) begin
         msiVecReg <= pickVec;
      end
   end

   assign msiValid = (stateReg == ST_SEND);
   assign msiVector = msiVecReg;

   ////////////////////////////////////////////////////////////////////
   // Read path

   always_comb begin
      rdDataNext = 32'h0;
      if (regAddr == `MVPS_OFF_CTRL) begin
         rdDataNext[`MVPS_EN_BIT] = ctrlReg.enable;
         rdDataNext[`MVPS_CAP_MSB:`MVPS_CAP_LSB] = CAP_COUNT;
         rdDataNext[`MVPS_GRANT_MSB:`MVPS_GRANT_LSB] = ctrlReg.grant;
         rdDataNext[`MVPS_A64_BIT] = ADDR64;
         rdDataNext[`MVPS_PVM_BIT] = 1'b1;
      end else if (regAddr == pendAddr) begin
         rdDataNext[3:0] = vecPend & implBits;
      end else if (regAddr == maskAddr) begin
         rdDataNext[3:0] = maskReg & implBits;
      end else if (regAddr == `MVPS_OFF_CAPHDR) begin
         rdDataNext[7:0] = `MVPS_CAP_ID;
         rdDataNext[15:8] = `MVPS_NEXT_PTR;
         rdDataNext[19:16] = `MVPS_CAP_VER;
         rdDataNext[23:20] = `MVPS_PORT_TYPE;
         rdDataNext[24] = 1'b0;
         rdDataNext[29:25] = MSG_NUM;
      end else if (regAddr == `MVPS_OFF_RSV0 ||
                   regAddr == `MVPS_OFF_RSV1 ||
                   regAddr == `MVPS_OFF_RSV2 ||
                   regAddr == `MVPS_OFF_RSV3) begin
         rdDataNext = 32'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdDataReg <= 32'h0;
      end else if (regRdEn) begin
         rdDataReg <= rdDataNext;
      end else begin
         rdDataReg <= 32'h0;
      end
   end

   assign regRdData = rdDataReg;

   ////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   logic pastRst;
   always_ff @(posedge mclk) begin
      pastRst <= sys_rst;
   end

   pend_set_a: assert property (evtIn.power |=> catPendReg.power)
      else $error("power event not latched as pending");

   link_set_a: assert property (evtIn.link |=> catPendReg.link)
      else $error("link event not latched as pending");

   mask_block_a: assert property (
      msiValid && !$past(msiValid) |-> !$past(maskReg[pickVec]))
      else $error("message started for a masked vector");

   four_vec_a: assert property (
      msiValid && effGrant == `MVPS_GRANT_4 |-> catPendReg[msiVector])
      else $error("four-vector message not tied to its category");

   two_vec_a: assert property (
      msiValid && effGrant == `MVPS_GRANT_2 |-> msiVector <= 2'h1)
      else $error("two-vector grant sent an ungranted vector");

   one_vec_a: assert property (
      msiValid && effGrant == `MVPS_GRANT_1 |-> msiVector == 2'h0)
      else $error("single grant sent a nonzero vector");

   send_soon_a: assert property (
      stateReg == ST_IDLE && ctrlReg.enable && |vecLive |=> msiValid)
      else $error("unmasked pending vector not sent");

   pend_addr_a: assert property (
      regRdEn && regAddr == pendAddr |=>
      regRdData == {28'h0, $past(vecPend & implBits)})
      else $error("pending register read wrong");

   link_rsv_a: assert property (
      regRdEn && regAddr == pendAddr && effGrant == `MVPS_GRANT_1
      |=> regRdData[3:1] == 3'h0)
      else $error("reserved pending bits nonzero under single grant");

   cap_hdr_a: assert property (
      regRdEn && regAddr == `MVPS_OFF_CAPHDR |=>
      regRdData[15:0] == {`MVPS_NEXT_PTR, `MVPS_CAP_ID} &&
      regRdData[24] == 1'b0)
      else $error("capability header read wrong");

   rsv_zero_a: assert property (
      regRdEn && (regAddr == `MVPS_OFF_RSV0 || regAddr == `MVPS_OFF_RSV3)
      |=> regRdData == 32'h0)
      else $error("reserved offset read nonzero");

   pvm_bit_a: assert property (
      regRdEn && regAddr == `MVPS_OFF_CTRL |=> regRdData[`MVPS_PVM_BIT])
      else $error("per-vector masking bit not set");

   mask_rst_a: assert property (
      pastRst |-> maskReg == `MVPS_MASK_RST && catPendReg == 4'h0)
      else $error("mask or pending not zero after reset");

   hold_send_a: assert property (
      msiValid && !msiReady |=> msiValid && $stable(msiVector))
      else $error("request dropped before acceptance");

   gpio_set_a: assert property (evtIn.gpio |=> catPendReg.gpio)
      else $error("pin event not latched as pending");

   door_set_a: assert property (
      evtIn.doorbell |=> catPendReg.doorbell)
      else $error("doorbell event not latched as pending");

   pend_hold_a: assert property (
      !sendDone |=> ($past(catPendReg) & ~catPendReg) == 4'h0)
      else $error("pending bit lost without a message");

   sent_clear_a: assert property (
      sendDone && !regWrEn && evtIn == 4'h0 |=>
      !vecPend[$past(msiVector)])
      else $error("sent vector still pending");

   send_gap_a: assert property (sendDone |=> !msiValid)
      else $error("no idle cycle after a message");

   off_quiet_a: assert property (
      stateReg == ST_IDLE && !ctrlReg.enable |=> !msiValid)
      else $error("message sent while disabled");

   low_first_a: assert property (
      msiValid && !$past(msiValid) |->
      ($past(vecLive) & ((4'h1 << msiVector) - 4'h1)) == 4'h0)
      else $error("lower live vector passed over");

   link_bit_a: assert property (
      regRdEn && regAddr == pendAddr && effGrant == `MVPS_GRANT_2
      |=> regRdData[1] == $past(catPendReg.link))
      else $error("link pending bit wrong under two vectors");

   shared_bit_a: assert property (
      regRdEn && regAddr == pendAddr && effGrant == `MVPS_GRANT_1
      |=> regRdData[0] == $past(catPendReg != 4'h0))
      else $error("shared pending bit wrong under single grant");

   pin_rsv_a: assert property (
      regRdEn && regAddr == pendAddr && effGrant == `MVPS_GRANT_2
      |=> regRdData[3:2] == 2'h0)
      else $error("pin or doorbell bit nonzero under two vectors");

   ctrl_ro_a: assert property (
      regRdEn && regAddr == `MVPS_OFF_CTRL |=>
      regRdData[`MVPS_CAP_MSB:`MVPS_CAP_LSB] == CAP_COUNT &&
      regRdData[`MVPS_A64_BIT] == ADDR64)
      else $error("control read-only fields wrong");

   cap_upper_a: assert property (
      regRdEn && regAddr == `MVPS_OFF_CAPHDR |=>
      regRdData[31:16] ==
      {2'h0, MSG_NUM, 1'b0, `MVPS_PORT_TYPE, `MVPS_CAP_VER})
      else $error("capability header upper half wrong");

   rsv_mid_a: assert property (
      regRdEn && (regAddr == `MVPS_OFF_RSV1 || regAddr == `MVPS_OFF_RSV2)
      |=> regRdData == 32'h0)
      else $error("reserved offset read nonzero");

   rd_idle_a: assert property (!regRdEn |=> regRdData == 32'h0)
      else $error("read data shown without a read");

   four_cov: cover property (
      msiValid && msiReady && effGrant == `MVPS_GRANT_4 && msiVector == 2'h3);
   two_cov: cover property (
      msiValid && msiReady && effGrant == `MVPS_GRANT_2 && msiVector == 2'h1);
   defer_cov: cover property (
      catPendReg.gpio && maskReg[2] ##1 !maskReg[2] ##[1:4] msiValid);
   race_cov: cover property (sendDone && |(evtIn & catClear));
   one_cov: cover property (
      msiValid && msiReady && effGrant == `MVPS_GRANT_1);

endmodule : mvps_msi_pending

/* sim/mvps_msg_host.sv */
// Message host model that accepts MSI requests and logs their vectors
`timescale 1ns/10ps
module mvps_msg_host (
   input wire logic mclk, // Core clock
   input wire logic sys_rst, // Synchronous reset, high
   input wire logic msiValid, // Request from device
   input wire logic [1:0] msiVector, // Vector of request
   input wire logic slowReply, // Stall before accepting
   output logic msiReady, // Acceptance pulse
   output logic [7:0] nMsg, // Messages taken
   output logic [3:0][1:0] vecLog // Vectors by arrival
);
   logic [2:0] waitCnt;

   ////////////////////////////////////////////////////////////////////////
   // Ready only after the request is seen, so it never leads valid
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         msiReady <= 1'b0;
         waitCnt <= 3'h0;
         nMsg <= 8'h00;
         vecLog <= '0;
      end else if (msiValid && msiReady) begin
         vecLog[nMsg[1:0]] <= msiVector;
         nMsg <= nMsg + 8'h01;
         msiReady <= 1'b0;
         waitCnt <= 3'h0;
      end else if (msiValid) begin
         if (!slowReply || waitCnt == 3'h4) begin
            msiReady <= 1'b1;
         end else begin
            waitCnt <= waitCnt + 3'h1;
         end
      end
   end
endmodule : mvps_msg_host

/* sim/tb_top.sv */
// Register and message scenarios for the MSI pending block
`timescale 1ns/10ps
`include "mvps_cfg.svh"
module tb_top import mvps_pkg::*; ;
   logic mclk;
   logic sys_rst;
   logic [11:0] regAddr;
   logic [31:0] regWrData;
   logic regWrEn;
   logic regRdEn;
   logic [31:0] rdA;
   logic [31:0] rdB;
   logic [31:0] alt;
   mvps_evt_t evtIn;
   logic msiValid;
   logic [1:0] msiVector;
   logic msiReady;
   logic slowReply;
   logic [7:0] nMsg;
   logic [3:0][1:0] vecLog;
   logic [11:0] rsv [4];
   int fails;
   int n_compared;

   mvps_msi_pending dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(rdA), .evtIn(evtIn), .msiValid(msiValid),
      .msiVector(msiVector), .msiReady(msiReady));
   // Narrow addressing copy, its messages are never accepted
   mvps_msi_pending #(.ADDR64(1'b0)) dut32 (.mclk(mclk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(rdB), .evtIn(evtIn), .msiValid(),
      .msiVector(), .msiReady(1'b0));
   mvps_msg_host host (.mclk(mclk), .sys_rst(sys_rst), .msiValid(msiValid),
      .msiVector(msiVector), .slowReply(slowReply), .msiReady(msiReady),
      .nMsg(nMsg), .vecLog(vecLog));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWrEn <= 1'b0;
   endtask : wr

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      @(posedge mclk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRdEn <= 1'b0;
      #1;
      alt = rdB;
      chk(rdA, exp);
   endtask : rdc

   task automatic pulse(input logic [3:0] e);
      @(posedge mclk);
      evtIn <= e;
      @(posedge mclk);
      evtIn <= '0;
   endtask : pulse

   task automatic waitMsg(input logic [7:0] n);
      int i;
      i = 0;
      while (nMsg !== n && i < 200) begin
         @(posedge mclk);
         i++;
      end
      #1;
      chk({24'h0, nMsg}, {24'h0, n});
   endtask : waitMsg

   task automatic results;
      $display("compared %0d mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      results();
   end

   initial begin
      sys_rst = 1'b1;
      regAddr = 12'h000;
      regWrData = 32'h0;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      evtIn = '0;
      slowReply = 1'b0;
      fails = 0;
      n_compared = 0;
      rsv = '{`MVPS_OFF_RSV0, `MVPS_OFF_RSV1, `MVPS_OFF_RSV2, `MVPS_OFF_RSV3};
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      // Read-only header, control fields, reserved places
      rdc(`MVPS_OFF_CAPHDR, 32'h0002A410);
      rdc(`MVPS_OFF_CAPHDR, 32'h0002A410);
      rdc(`MVPS_OFF_CTRL, 32'h01840000);
      chk(alt, 32'h01040000);
      rdc(`MVPS_OFF_MASK32, 32'h0);
      for (int i = 0; i < 4; i++) begin
         wr(rsv[i], 32'hFFFFFFFF);
         rdc(rsv[i], 32'h0);
      end
      $display("test header done");
      // Held while messages are disabled, sent once enabled
      wr(`MVPS_OFF_CTRL, 32'h00200000);
      pulse(4'h1);
      repeat (10) @(posedge mclk);
      #1;
      chk({24'h0, nMsg}, 32'h0);
      rdc(`MVPS_OFF_PEND64, 32'h1);
      wr(`MVPS_OFF_CTRL, 32'h00210000);
      rdc(`MVPS_OFF_CTRL, 32'h01A50000);
      waitMsg(8'h01);
      chk({30'h0, vecLog[0]}, 32'h0);
      $display("test enable done");
      // Four vectors: masked pending, then deferred messages in order
      wr(`MVPS_OFF_MASK64, 32'hF);
      rdc(`MVPS_OFF_MASK64, 32'hF);
      pulse(4'hF);
      repeat (10) @(posedge mclk);
      #1;
      chk({24'h0, nMsg}, 32'h1);
      rdc(`MVPS_OFF_PEND64, 32'hF);
      chk(alt, 32'h0);
      rdc(`MVPS_OFF_PEND32, 32'hF);
      chk(alt, 32'hF);
      wr(`MVPS_OFF_MASK64, 32'h0);
      waitMsg(8'h05);
      for (int i = 0; i < 4; i++) begin
         chk({30'h0, vecLog[(i + 1) % 4]}, i);
      end
      rdc(`MVPS_OFF_PEND64, 32'h0);
      $display("test four vectors done");
      // Two vectors, slow host
      @(posedge mclk);
      slowReply <= 1'b1;
      wr(`MVPS_OFF_MASK64, 32'hF);
      wr(`MVPS_OFF_CTRL, 32'h00110000);
      rdc(`MVPS_OFF_MASK64, 32'h3);
      pulse(4'h6);
      rdc(`MVPS_OFF_PEND64, 32'h3);
      pulse(4'h8);
      rdc(`MVPS_OFF_PEND64, 32'h3);
      wr(`MVPS_OFF_MASK64, 32'h0);
      waitMsg(8'h07);
      chk({30'h0, vecLog[1]}, 32'h0);
      chk({30'h0, vecLog[2]}, 32'h1);
      $display("test two vectors done");
      // Grant above capable clamps to four, then one vector, prompt host
      @(posedge mclk);
      slowReply <= 1'b0;
      wr(`MVPS_OFF_MASK64, 32'hF);
      wr(`MVPS_OFF_CTRL, 32'h00310000);
      rdc(`MVPS_OFF_CTRL, 32'h01B50000);
      rdc(`MVPS_OFF_MASK64, 32'hF);
      wr(`MVPS_OFF_CTRL, 32'h00010000);
      rdc(`MVPS_OFF_MASK64, 32'h1);
      pulse(4'h2);
      rdc(`MVPS_OFF_PEND64, 32'h1);
      wr(`MVPS_OFF_MASK64, 32'h0);
      waitMsg(8'h08);
      chk({30'h0, vecLog[3]}, 32'h0);
      $display("test one vector done");
      results();
   end
endmodule : tb_top
